// >>> hw/iface_clk_pkg.sv
`default_nettype none
package iface_clk_pkg;
	localparam int unsigned HALF_W       = 12;
	localparam int unsigned BUS_W        = 24;
	localparam int unsigned FIFO_DEPTH   = 4;
	localparam int unsigned PLL_HALF_CYC = 2;
	localparam logic [1:0]  INTERP_1X    = 2'h0;
	localparam logic [1:0]  INTERP_2X    = 2'h1;
	localparam logic [1:0]  INTERP_4X    = 2'h2;
	localparam logic        DUPLEX_FULL  = 1'h1;
	localparam logic        WIDTH_NARROW = 1'h1;
	localparam logic        SRC_PLL      = 1'h1;

	typedef enum logic [1:0] {
		full_duplex_mode,
		half_duplex_wide_mode,
		half_duplex_narrow_mode
	} bus_mode_t;

	typedef struct packed {
		bus_mode_t  mode;
		logic [1:0] interp;
		logic [1:0] pll_code;
		logic       pll_bypass;
		logic       sync_opt;
		logic       err;
	} strap_cfg_t;

	typedef struct packed {
		logic [HALF_W-1:0] hi;
		logic [HALF_W-1:0] lo;
	} word_t;
endpackage
`default_nettype wire

// >>> hw/rx_fifo.sv
`default_nettype none
module rx_fifo
	import iface_clk_pkg::*;
#(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	// Clock
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             ce,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("rx_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wr_ptr_r;
	logic [AW:0]      rd_ptr_r;
	logic             push;
	logic             pop;

	// Pointers carry one extra bit so full and empty are told apart
	assign out_valid = (wr_ptr_r != rd_ptr_r);
	assign in_ready  = (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]) || (wr_ptr_r[AW] == rd_ptr_r[AW]);
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;
	assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

	always_ff @(posedge mclk) begin
		if (push) begin
			mem_r[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + (AW+1)'(1);
			end
		end
	end
endmodule
`default_nettype wire

// >>> hw/iface_clock_ctrl.sv
`default_nettype none
module iface_clock_ctrl
	import iface_clk_pkg::*;
#(
	parameter int unsigned PLL_HALF = PLL_HALF_CYC
) (
	// Clock, reset, enable
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              ce,
	// Reference clock pins
	input  wire logic              ref_clk_a,
	input  wire logic              ref_clk_b,
	// Strap pins
	input  wire logic              duplex_strap,
	input  wire logic              width_strap,
	input  wire logic              interp_sel_hi,
	input  wire logic              interp_sel_lo,
	input  wire logic              sync_opt_strap,
	input  wire logic              spi_cs_n,
	// Control bits
	input  wire logic              secondary_clk_out_en,
	input  wire logic              secondary_clk_src_sel,
	// Interface pins
	input  wire logic              tx_rx_select_pin,
	output logic                   primary_iface_clk,
	output logic                   secondary_iface_pin_out,
	output logic                   secondary_iface_pin_oe_n,
	input  wire logic [BUS_W-1:0]  bus_in,
	output logic [BUS_W-1:0]       bus_out,
	output logic [BUS_W-1:0]       bus_oe_n,
	// Decoded configuration
	output strap_cfg_t             cfg,
	output logic                   cfg_valid,
	// Transmit words to the converter side
	output logic                   tx_valid,
	output word_t                  tx_word,
	// Receive words from the converter side
	input  wire logic              rx_valid,
	output logic                   rx_ready,
	input  wire word_t             rx_word
);
	generate
		if (PLL_HALF < 1 || PLL_HALF > 255) begin : g_bad_pll
			$error("PLL_HALF must lie in 1..255");
		end
	endgenerate

	// Every pin from outside mclk passes two flip-flops
	logic [8:0]       pin_meta_r;
	logic [8:0]       pin_sync_r;
	logic [BUS_W-1:0] bus_meta_r;
	logic [BUS_W-1:0] bus_sync_r;

	always_ff @(posedge mclk) begin
		if (ce) begin
			pin_meta_r <= {ref_clk_a, ref_clk_b, duplex_strap, width_strap, interp_sel_hi,
				interp_sel_lo, sync_opt_strap, spi_cs_n, tx_rx_select_pin};
			pin_sync_r <= pin_meta_r;
			bus_meta_r <= bus_in;
			bus_sync_r <= bus_meta_r;
		end
	end

	logic ref_a_s;
	logic ref_b_s;
	logic tx_sel_s;
	assign ref_a_s  = pin_sync_r[8];
	assign ref_b_s  = pin_sync_r[7];
	assign tx_sel_s = pin_sync_r[0];

	// Straps are caught while reset is held; the board keeps them static after
	strap_cfg_t cfg_r;
	strap_cfg_t cfg_nxt;
	logic       cfg_valid_r;

	always_comb begin
		cfg_nxt            = '0;
		cfg_nxt.interp     = pin_sync_r[4:3];
		cfg_nxt.pll_code   = pin_sync_r[4:3];
		cfg_nxt.pll_bypass = (pin_sync_r[4:3] == INTERP_1X);
		cfg_nxt.sync_opt   = pin_sync_r[2];
		if (pin_sync_r[6] == DUPLEX_FULL) begin
			cfg_nxt.mode = full_duplex_mode;
			cfg_nxt.err  = (pin_sync_r[4:3] != INTERP_2X) && (pin_sync_r[4:3] != INTERP_4X);
		end else begin
			cfg_nxt.mode = (pin_sync_r[5] == WIDTH_NARROW) ? half_duplex_narrow_mode
				: half_duplex_wide_mode;
			cfg_nxt.err  = (pin_sync_r[4:3] == 2'h3);
			if (pin_sync_r[5] == WIDTH_NARROW && pin_sync_r[4:3] == INTERP_1X) begin
				cfg_nxt.err = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_r       <= cfg_nxt;
			cfg_valid_r <= !pin_sync_r[1];
		end
	end

	logic is_fd;
	logic interleaved;
	assign is_fd       = (cfg_r.mode == full_duplex_mode);
	assign interleaved = (cfg_r.mode != half_duplex_wide_mode);

	// PLL stand-in: follows reference B when bypassed, else a fixed-rate divider
	logic [7:0] pll_cnt_r;
	logic       pll_clk_r;
	logic       pll_tick;
	logic       pll_rise;

	assign pll_tick = cfg_r.pll_bypass ? (ref_b_s != pll_clk_r)
		: (pll_cnt_r == 8'(PLL_HALF - 1));
	assign pll_rise = pll_tick && !pll_clk_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			pll_cnt_r <= 8'h00;
			pll_clk_r <= 1'b0;
		end else if (ce) begin
			pll_cnt_r <= pll_tick ? 8'h00 : pll_cnt_r + 8'h01;
			pll_clk_r <= pll_clk_r ^ pll_tick;
		end
	end

	// Primary clock: reference A in full duplex, else PLL divided by interpolation, divisor halved when interleaved
	logic [1:0] div_code;
	logic       div_cnt_r;
	logic       prim_r;
	logic       prim_q_r;
	logic       prim_nxt;
	logic       prim_rise;
	logic       prim_fall;

	assign div_code = (interleaved && cfg_r.interp != INTERP_1X) ? cfg_r.interp - 2'h1
		: cfg_r.interp;

	always_comb begin
		if (is_fd) begin
			prim_nxt = ref_a_s;
		end else begin
			unique case (div_code)
				2'h0: prim_nxt = pll_clk_r ^ pll_tick;
				2'h1: prim_nxt = prim_r ^ pll_rise;
				default: prim_nxt = prim_r ^ (pll_rise && div_cnt_r);
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			div_cnt_r <= 1'b0;
			prim_r    <= 1'b0;
			prim_q_r  <= 1'b0;
		end else if (ce) begin
			div_cnt_r <= div_cnt_r ^ pll_rise;
			prim_r    <= prim_nxt;
			prim_q_r  <= prim_r;
		end
	end

	assign prim_rise         = prim_r && !prim_q_r;
	assign prim_fall         = !prim_r && prim_q_r;
	assign primary_iface_clk = prim_r;

	// Secondary pin
	logic rx_sync_r;
	logic sec_r;
	logic sec_oe_n_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sec_r      <= 1'b0;
			sec_oe_n_r <= 1'b1;
		end else if (ce) begin
			if (is_fd) begin
				sec_oe_n_r <= 1'b0;
				// Enable inverts the clock in full duplex; with the sync option the pin carries rx_sync_r instead
				sec_r <= cfg_r.sync_opt ? rx_sync_r : ref_a_s ^ secondary_clk_out_en;
			end else if (secondary_clk_out_en) begin
				sec_oe_n_r <= 1'b0;
				sec_r      <= (secondary_clk_src_sel == SRC_PLL) ? pll_clk_r : ref_a_s;
			end else begin
				sec_oe_n_r <= 1'b1;
				sec_r      <= 1'b0;
			end
		end
	end

	assign secondary_iface_pin_out  = sec_r;
	assign secondary_iface_pin_oe_n = sec_oe_n_r;

	// Transmit capture
	logic              tx_active;
	logic              tx_half_r;
	logic [HALF_W-1:0] tx_hi_r;
	logic [HALF_W-1:0] tx_lane;
	logic              tx_valid_r;
	word_t             tx_word_r;

	assign tx_active = is_fd || tx_sel_s;
	assign tx_lane   = is_fd ? bus_sync_r[BUS_W-1:HALF_W] : bus_sync_r[HALF_W-1:0];

	always_ff @(posedge mclk) begin
		if (rst) begin
			tx_half_r  <= 1'b0;
			tx_hi_r    <= '0;
			tx_valid_r <= 1'b0;
			tx_word_r  <= '0;
		end else if (ce) begin
			tx_valid_r <= 1'b0;
			if (prim_fall && tx_active) begin
				if (!interleaved) begin
					tx_word_r  <= bus_sync_r;
					tx_valid_r <= 1'b1;
				end else if (!tx_half_r) begin
					tx_hi_r   <= tx_lane;
					tx_half_r <= 1'b1;
				end else begin
					tx_word_r  <= {tx_hi_r, tx_lane};
					tx_valid_r <= 1'b1;
					tx_half_r  <= 1'b0;
				end
			end
		end
	end

	assign tx_valid = tx_valid_r;
	assign tx_word  = tx_word_r;

	// Receive launch through the FIFO; when it runs dry the bus holds the last word, or its low half when interleaved
	logic              rx_active;
	logic              rx_half_r;
	logic              fifo_valid;
	logic              fifo_pop;
	word_t             fifo_word;
	logic [HALF_W-1:0] rx_lo_r;
	logic [BUS_W-1:0]  bus_out_r;
	logic [BUS_W-1:0]  oe_mask;
	logic [BUS_W-1:0]  bus_oe_n_r;
	logic              sync_pin;

	assign rx_active = is_fd || !tx_sel_s;
	assign fifo_pop  = prim_rise && rx_active && !(interleaved && rx_half_r);
	assign sync_pin  = cfg_r.sync_opt && (cfg_r.mode == half_duplex_narrow_mode);

	rx_fifo #(
		.WIDTH ($bits(word_t)),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.ce        (ce),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.in_data   (rx_word),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_word)
	);

	always_ff @(posedge mclk) begin
		if (rst) begin
			rx_half_r <= 1'b0;
			rx_lo_r   <= '0;
			rx_sync_r <= 1'b0;
			bus_out_r <= '0;
		end else if (ce && prim_rise && rx_active) begin
			if (!interleaved) begin
				if (fifo_valid) begin
					bus_out_r <= fifo_word;
				end
			end else if (!rx_half_r) begin
				if (fifo_valid) begin
					bus_out_r[HALF_W-1:0] <= fifo_word.hi;
					bus_out_r[BUS_W-1]    <= 1'b0;
					rx_lo_r               <= fifo_word.lo;
					rx_half_r             <= 1'b1;
					rx_sync_r             <= 1'b0;
				end
			end else begin
				bus_out_r[HALF_W-1:0] <= rx_lo_r;
				bus_out_r[BUS_W-1]    <= sync_pin;
				rx_half_r             <= 1'b0;
				rx_sync_r             <= 1'b1;
			end
		end
	end

	always_comb begin
		oe_mask = '0;
		if (is_fd) begin
			oe_mask[HALF_W-1:0] = '1;
		end else if (rx_active) begin
			if (interleaved) begin
				oe_mask[HALF_W-1:0] = '1;
				oe_mask[BUS_W-1]    = sync_pin;
			end else begin
				oe_mask = '1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_oe_n_r <= '1;
		end else if (ce) begin
			bus_oe_n_r <= ~oe_mask;
		end
	end

	assign bus_out   = bus_out_r;
	assign bus_oe_n  = bus_oe_n_r;
	assign cfg       = cfg_r;
	assign cfg_valid = cfg_valid_r;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_sec_pll_src: assert property (ce && !is_fd && secondary_clk_out_en
		&& secondary_clk_src_sel |=> secondary_iface_pin_out == $past(pll_clk_r)
		&& !secondary_iface_pin_oe_n) else $error("secondary pin is not the PLL clock");
	a_sec_ref_src: assert property (ce && !is_fd && secondary_clk_out_en
		&& !secondary_clk_src_sel |=> secondary_iface_pin_out == $past(ref_a_s))
		else $error("secondary pin is not the reference clock");
	a_prim_from_pll: assert property (!is_fd && $changed(primary_iface_clk)
		|-> $past(pll_tick)) else $error("primary clock moved without a PLL edge");
	// The pin enable is still in its reset state at the first edge after release
	a_two_clocks_fd: assert property (is_fd && $past(ce) && !$past(rst)
		|-> !secondary_iface_pin_oe_n) else $error("secondary clock not driven in full duplex");
	a_tx_on_fall: assert property (tx_valid |-> $past(prim_fall))
		else $error("transmit word not taken at a falling edge");
	a_rx_after_rise: assert property ($changed(bus_out) |-> $past(prim_rise))
		else $error("receive data moved away from a rising edge");
	a_fd_rise_align: assert property (is_fd && !cfg_r.sync_opt && !secondary_clk_out_en
		&& $rose(primary_iface_clk) |-> $rose(secondary_iface_pin_out))
		else $error("full duplex clocks not aligned");
	a_strap_decode: assert property (cfg.pll_bypass == (cfg.interp == INTERP_1X)
		&& (cfg.interp != 2'h3 || cfg.err) && $stable(cfg))
		else $error("strap decode inconsistent");
	a_fd_interp_ok: assert property (is_fd && cfg.interp == INTERP_1X |-> cfg.err)
		else $error("full duplex accepted 1x interpolation");
	a_fd_sync_pin: assert property (is_fd && cfg_r.sync_opt && ce
		|=> secondary_iface_pin_out == $past(rx_sync_r)) else $error("full duplex sync lost");
	a_half_duplex_narrow_mode_sync_bit: assert property (sync_pin && rx_active && $rose(rx_sync_r)
		|-> bus_out[BUS_W-1] && bus_out[HALF_W-1:0] == $past(rx_lo_r))
		else $error("narrow sync not with low half");

	c_tx_word: cover property (tx_valid && interleaved);
	c_rx_pair: cover property ($rose(rx_sync_r) ##[1:64] $rose(rx_sync_r));
	c_fifo_full: cover property (rx_valid && !rx_ready);
endmodule
`default_nettype wire

// >>> verif/back_end_model.sv
`default_nettype none
module back_end_model
	import iface_clk_pkg::*;
(
	// Pins
	input  wire logic             clk_in,
	input  wire logic [BUS_W-1:0] bus_out,
	input  wire logic [BUS_W-1:0] bus_oe_n,
	output logic [BUS_W-1:0]      bus_in,
	// Control
	input  wire logic             tx_en,
	input  wire logic             narrow,
	input  wire logic [BUS_W-1:0] seed
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [BUS_W-1:0]  drv_r = '0;
	logic [HALF_W-1:0] hi_r  = '0;
	logic [BUS_W-1:0]  txq[$];
	logic [BUS_W-1:0]  rxq[$];

	// Released lanes show the last value while transmitting, else its inverse, never a stale copy
	assign bus_in = (bus_out & ~bus_oe_n) | ((tx_en ? drv_r : ~drv_r) & bus_oe_n);

	function automatic void add_rx(input logic [BUS_W-1:0] w);
		if (rxq.size() == 0 || rxq[$] !== w)
			rxq.push_back(w);
	endfunction

	// New data after the rising edge, so it stands across the falling edge
	always @(posedge clk_in) begin
		drv_r <= drv_r * 24'h00019D + seed;
	end

	always @(negedge clk_in) begin
		if (tx_en)
			txq.push_back(drv_r);
		else if (!bus_oe_n[0] && !narrow)
			add_rx(bus_out);
		else if (!bus_oe_n[0] && bus_out[BUS_W-1])
			add_rx({hi_r, bus_out[HALF_W-1:0]});
		else if (!bus_oe_n[0])
			hi_r <= bus_out[HALF_W-1:0];
	end
endmodule
`default_nettype wire

// >>> verif/iface_clock_ctrl_tb.sv
`default_nettype none
module iface_clock_ctrl_tb
	import iface_clk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PLL_H = 4;
	logic             mclk = 0, rst = 1, ref_clk_a = 0, ref_clk_b = 0;
	logic             duplex_strap = 0, width_strap = 0, interp_sel_hi = 0, interp_sel_lo = 1;
	logic             sync_opt_strap = 0, spi_cs_n = 0, tx_rx_select_pin = 1;
	logic             secondary_clk_out_en = 0, secondary_clk_src_sel = 0;
	logic             primary_iface_clk, secondary_iface_pin_out, secondary_iface_pin_oe_n;
	logic [BUS_W-1:0] bus_in, bus_out, bus_oe_n;
	logic [BUS_W-1:0] seed = 24'h000001;
	strap_cfg_t       cfg;
	logic             cfg_valid, tx_valid, rx_ready, rx_valid = 0, tx_en = 0, narrow = 0;
	logic             ce = 1;
	word_t            tx_word;
	word_t            rx_word = '0;
	int               fails = 0;
	int               samples_checked = 0;

	initial forever #4 mclk = ~mclk;
	initial forever #80 ref_clk_a = ~ref_clk_a;
	initial #37 forever #80 ref_clk_b = ~ref_clk_b;

	iface_clock_ctrl #(.PLL_HALF(PLL_H)) i_dut (
		.mclk, .rst, .ce, .ref_clk_a, .ref_clk_b, .duplex_strap, .width_strap,
		.interp_sel_hi, .interp_sel_lo, .sync_opt_strap, .spi_cs_n, .secondary_clk_out_en,
		.secondary_clk_src_sel, .tx_rx_select_pin, .primary_iface_clk,
		.secondary_iface_pin_out, .secondary_iface_pin_oe_n, .bus_in, .bus_out, .bus_oe_n,
		.cfg, .cfg_valid, .tx_valid, .tx_word, .rx_valid, .rx_ready, .rx_word
	);
	back_end_model i_be (
		.clk_in(primary_iface_clk), .bus_out, .bus_oe_n, .bus_in, .tx_en, .narrow, .seed
	);

	task automatic chk(input string nm, input logic [BUS_W-1:0] e, input logic [BUS_W-1:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Clock rates are counted over a window, so one edge either way is allowed
	task automatic chk_n(input string nm, input int e, input int g);
		samples_checked++;
		if (g < e - 1 || g > e + 1) begin
			fails++;
			$display("BAD %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Straps change only under reset, bits {duplex, width, hi, lo, option}
	task automatic boot(input logic [4:0] s);
		@(negedge mclk);
		{duplex_strap, width_strap, interp_sel_hi, interp_sel_lo, sync_opt_strap} = s;
		rst = 1;
		repeat (12) @(negedge mclk);
		rst = 0;
		repeat (4) @(negedge mclk);
	endtask

	task automatic t_straps();
		bus_mode_t  m;
		logic [1:0] ip;
		for (int i = 0; i < 16; i++) begin
			spi_cs_n = (i == 9);
			boot({i[3:0], 1'($urandom)});
			ip = i[1:0];
			m = i[3] ? full_duplex_mode : (i[2] ? half_duplex_narrow_mode : half_duplex_wide_mode);
			chk("cfg_valid", 24'(i != 9), 24'(cfg_valid));
			if (i != 9) begin
				chk("mode", 24'(m), 24'(cfg.mode));
				chk("interp", 24'(ip), 24'(cfg.interp));
				chk("bypass", 24'(ip == INTERP_1X), 24'(cfg.pll_bypass));
				chk("err", 24'(ip == 2'h3 || (ip == INTERP_1X && i[3:2] != 0)), 24'(cfg.err));
			end
		end
		spi_cs_n = 0;
		$display("test straps done");
	endtask

	task automatic count(output int pr, output int sr);
		logic lp;
		logic ls;
		pr = 0;
		sr = 0;
		lp = primary_iface_clk;
		ls = secondary_iface_pin_out;
		repeat (320) begin
			@(negedge mclk);
			pr += int'(primary_iface_clk && !lp);
			sr += int'(secondary_iface_pin_out && !ls);
			lp = primary_iface_clk;
			ls = secondary_iface_pin_out;
		end
	endtask

	task automatic t_clocks();
		int pr;
		int sr;
		boot(5'b00010);
		for (int k = 0; k < 3; k++) begin
			secondary_clk_out_en = (k != 0);
			secondary_clk_src_sel = (k == 1);
			repeat (8) @(negedge mclk);
			count(pr, sr);
			chk("sec_oe_n", 24'(k == 0), 24'(secondary_iface_pin_oe_n));
			chk_n("prim_rises", 320 / (4 * PLL_H), pr);
			if (k > 0) chk_n("sec_rises", k == 1 ? 320 / (2 * PLL_H) : 16, sr);
		end
		// With the enable low both generated clocks must hold still
		ce = 0;
		count(pr, sr);
		chk("frozen_prim", 24'h000000, 24'(pr));
		chk("frozen_sec", 24'h000000, 24'(sr));
		ce = 1;
		secondary_clk_out_en = 0;
		boot(5'b10010);
		count(pr, sr);
		chk("fd_oe_n", 24'h000000, 24'(secondary_iface_pin_oe_n));
		chk_n("fd_sec", 16, sr);
		chk_n("fd_prim", 16, pr);
		$display("test clocks done");
	endtask

	task automatic t_tx();
		tx_rx_select_pin = 1;
		boot(5'b00010);
		tx_en = 1;
		repeat (40) @(negedge mclk);
		chk("tx_oe_n", 24'hFFFFFF, bus_oe_n);
		@(posedge primary_iface_clk);
		i_be.txq.delete();
		for (int n = 0; n < 12; n++) begin
			@(negedge mclk);
			for (int t = 0; t < 100 && tx_valid !== 1'b1; t++)
				@(negedge mclk);
			chk("tx_valid", 24'h000001, 24'(tx_valid));
			chk("tx_word", i_be.txq.pop_front(), tx_word);
		end
		tx_en = 0;
		$display("test transmit done");
	endtask

	task automatic t_rx(input logic [4:0] s);
		logic [BUS_W-1:0] q[$];
		logic [BUS_W-1:0] w;
		tx_rx_select_pin = 1;
		boot(s);
		narrow = s[3];
		for (int n = 0; n < 6 && q.size() == n; n++) begin
			w = BUS_W'($urandom);
			rx_word = w;
			rx_valid = 1;
			if (rx_ready === 1'b1)
				q.push_back(w);
			@(negedge mclk);
		end
		rx_valid = 0;
		chk("accepted", 24'(FIFO_DEPTH), 24'(q.size()));
		i_be.rxq.delete();
		tx_rx_select_pin = 0;
		repeat (300) @(negedge mclk);
		if (!s[3]) chk("rx_oe_n", 24'h000000, bus_oe_n);
		while (i_be.rxq.size() > 0 && i_be.rxq[0] !== q[0])
			void'(i_be.rxq.pop_front());
		foreach (q[k]) chk("rx_word", q[k], i_be.rxq.size() > k ? i_be.rxq[k] : 'x);
		$display("test receive done");
	endtask

	initial begin
		void'($urandom(7826));
		seed = BUS_W'($urandom) | 24'h000001;
		t_straps();
		t_clocks();
		t_tx();
		t_rx(5'b00010);
		t_rx(5'b01011);
		end_of_test();
	end

	initial begin
		#100000;
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
